//--- rtl/ast_pkg.sv
// Constants for the asynchronous serial transceiver
package ast_pkg;
   localparam logic [4:0] CTRL1_OFS = 5'h00;
   localparam logic [4:0] CTRL2_OFS = 5'h04;
   localparam logic [4:0] STAT_OFS = 5'h08;
   localparam logic [4:0] BAUD_OFS = 5'h0C;
   localparam logic [4:0] DATA_OFS = 5'h10;
   localparam logic [4:0] RXEP_OFS = 5'h14;
   localparam logic [4:0] TXEP_OFS = 5'h18;
   // Control one fields
   localparam int C1_RX9 = 7;
   localparam int C1_TX9 = 6;
   localparam int C1_WL = 4;
   // Control two fields
   localparam int C2_TEIE = 7;
   localparam int C2_TX_DONE_IRQ_EN = 6;
   localparam int C2_RIE = 5;
   localparam int C2_IDLE_IRQ_EN = 4;
   localparam int C2_TXON = 3;
   localparam int C2_RXON = 2;
   localparam int C2_BRK = 0;
   // Status fields
   localparam int S_TX_EMPTY_FLAG = 7;
   localparam int S_TC = 6;
   localparam int S_RX_FULL_FLAG = 5;
   localparam int S_IDLE = 4;
   localparam int S_OR = 3;
   localparam int S_NF = 2;
   localparam int S_FE = 1;
   localparam logic [7:0] STAT_RST = 8'hC0;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_S1 = 4'h7;
   localparam logic [3:0] OVS_S2 = 4'h8;
   localparam logic [3:0] OVS_S3 = 4'h9;
   localparam logic [3:0] OVS_HALF = 4'h7;
   localparam logic [3:0] FRAME8 = 4'hA;
   localparam logic [3:0] FRAME9 = 4'hB;
   localparam logic [3:0] DIV_1 = 4'h1;
   localparam logic [3:0] DIV_3 = 4'h3;
   localparam logic [3:0] DIV_4 = 4'h4;
   localparam logic [3:0] DIV_13 = 4'hD;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_PRE = 2'b01, TX_SHIFT = 2'b11,
      TX_MARK = 2'b10} ast_tx_e;
endpackage : ast_pkg

//--- rtl/async_serial_transceiver.sv
// Asynchronous serial transceiver with AXI4-Lite register slave
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Word length is 8 or 9 bits by the word length control bit.
// - Output is low for the start bit and high for the stop bit.
// - Idle character is 10 or 11 high bit times by word length.
// - Break is 10 low bits (plus a high 11th at 9-bit length), then one extra high bit.
// - Transmit LSB first; ninth bit taken from tx_ninth_bit.
// - Enabling transmitter sends 10 or 11 ones before first character.
// - Status read then data write clears tx empty and done flags.
// - Tx empty sets when buffer moves to shifter; interrupt when enabled.
// - Write while busy waits in buffer; write while idle starts at once.
// - Done sets after stop bit or break; interrupt when enabled.
// - Break repeats while send_break set; one high bit after last.
// - Toggling tx_on mid-character queues preamble, discards buffered data.
// - Receive LSB first; ninth bit stored in rx_ninth_bit.
// - Setting rx_on enables receiver to hunt for a start bit.
// - Received character goes to buffer, sets full flag, interrupt.
// - Status read then data read clears full flag; else overrun.
// - Idle line after activity sets idle flag only; interrupt when enabled.
// - Overrun sets flag, keeps buffer, interrupt; cleared by sequence.
// - Noise sets flag with full flag; no own interrupt; sequence clears.
// - Missing stop or break sets framing flag; sequence clears.
// - Received break reports framing with data 00h.
// - Baud is clock over 16, base divisor and power of two.
// - Nonzero extended prescaler divides the bit clock further.
// - Enabled idle output is high; disabled releases pin to port.
module async_serial_transceiver (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_en,
   output logic irq
);
   logic [7:0] ctrl1Q, ctrl2Q, baudQ, rxEpQ, txEpQ, statQ;
   logic [4:0] awAddrQ;
   logic [31:0] wDataQ;
   logic awHeldQ, wHeldQ, wStrbQ, statSeenQ;
   logic wrFire, rdFire, dataWr, dataRd;
   logic wordLen, txOn, rxOn;
   assign wordLen = ctrl1Q[ast_pkg::C1_WL];
   assign txOn = ctrl2Q[ast_pkg::C2_TXON];
   assign rxOn = ctrl2Q[ast_pkg::C2_RXON];
   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: address and data latched independently
   assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
   assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wrFire = awHeldQ && wHeldQ && !s_axi_bvalid;
   assign rdFire = s_axi_arvalid && s_axi_arready;
   assign dataWr = wrFire && wStrbQ && awAddrQ == ast_pkg::DATA_OFS;
   assign dataRd = rdFire && s_axi_araddr == ast_pkg::DATA_OFS;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         awAddrQ <= 5'h00;
         wDataQ <= 32'h0;
         wStrbQ <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ast_pkg::AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeldQ <= 1'b1;
            awAddrQ <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeldQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            // Strobe kept with its data; the master may move on after the handshake
            wStrbQ <= s_axi_wstrb[0];
         end
         if (wrFire)
         begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddrQ > ast_pkg::TXEP_OFS || awAddrQ[1:0] != 2'h0 ||
               awAddrQ == ast_pkg::STAT_OFS) ? ast_pkg::AXI_SLVERR : ast_pkg::AXI_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Only byte lane 0 carries register bits
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctrl1Q[ast_pkg::C1_TX9:0] <= 7'h00;
         ctrl2Q <= 8'h00;
         baudQ <= 8'h00;
         rxEpQ <= 8'h00;
         txEpQ <= 8'h00;
      end
      else if (wrFire && wStrbQ)
      begin
         unique case (awAddrQ)
            ast_pkg::CTRL1_OFS: ctrl1Q[ast_pkg::C1_TX9:0] <= wDataQ[ast_pkg::C1_TX9:0];
            ast_pkg::CTRL2_OFS: ctrl2Q <= wDataQ[7:0];
            ast_pkg::BAUD_OFS: baudQ <= wDataQ[7:0];
            ast_pkg::RXEP_OFS: rxEpQ <= wDataQ[7:0];
            ast_pkg::TXEP_OFS: txEpQ <= wDataQ[7:0];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Baud generators: one 16x tick per channel
   function automatic logic [3:0] baseDiv(input logic [1:0] sel);
      unique case (sel)
         2'h0: baseDiv = ast_pkg::DIV_1;
         2'h1: baseDiv = ast_pkg::DIV_3;
         2'h2: baseDiv = ast_pkg::DIV_4;
         default: baseDiv = ast_pkg::DIV_13;
      endcase
   endfunction : baseDiv
   logic [1:0] tick16;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gBaud
         logic [18:0] cntQ;
         logic [18:0] lim;
         logic [7:0] ep;
         logic [2:0] pow;
         assign ep = (g == 0) ? txEpQ : rxEpQ;
         assign pow = (g == 0) ? baudQ[5:3] : baudQ[2:0];
         assign lim = 19'((({15'h0, baseDiv(baudQ[7:6])} << pow) *
            ((ep == 8'h00) ? 19'h1 : {11'h0, ep})) - 19'h1);
         always_ff @(posedge mclk)
         begin
            if (!rst_n || cntQ >= lim)
               cntQ <= 19'h0;
            else
               cntQ <= cntQ + 19'h1;
         end
         assign tick16[g] = (cntQ >= lim);
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   ast_pkg::ast_tx_e txStQ;
   logic [9:0] txShQ;
   logic [8:0] tdrQ;
   logic [3:0] txOvsQ, txBitQ;
   logic tdrFullQ, txOnQ, prePendQ, brkTailQ, txLineQ, tdreSet, tcSet, frameEnd;
   logic [3:0] frameBits;
   assign frameBits = wordLen ? ast_pkg::FRAME9 : ast_pkg::FRAME8;
   assign frameEnd = tick16[0] && txOvsQ == ast_pkg::OVS_LAST && txBitQ == frameBits - 4'h1;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         txStQ <= ast_pkg::TX_IDLE;
         txShQ <= 10'h3FF;
         tdrQ <= 9'h0;
         tdrFullQ <= 1'b0;
         txOvsQ <= 4'h0;
         txBitQ <= 4'h0;
         txOnQ <= 1'b0;
         prePendQ <= 1'b0;
         brkTailQ <= 1'b0;
         txLineQ <= 1'b1;
      end
      else
      begin
         txOnQ <= txOn;
         if (txOn && !txOnQ)
            prePendQ <= 1'b1;
         if (!txOn)
            tdrFullQ <= 1'b0;
         if (tick16[0] && txStQ != ast_pkg::TX_IDLE)
            txOvsQ <= txOvsQ + 4'h1;
         if (tick16[0] && txOvsQ == ast_pkg::OVS_LAST && txStQ != ast_pkg::TX_IDLE)
         begin
            txBitQ <= txBitQ + 4'h1;
            txShQ <= {1'b1, txShQ[9:1]};
            txLineQ <= txShQ[1];
         end
         if (dataWr && txOn)
         begin
            tdrQ <= {ctrl1Q[ast_pkg::C1_TX9], wDataQ[7:0]};
            tdrFullQ <= 1'b1;
         end
         if (txStQ == ast_pkg::TX_IDLE || frameEnd)
         begin
            txOvsQ <= 4'h0;
            txBitQ <= 4'h0;
            // A cleared enable lets the character in flight finish first
            if (!txOn)
            begin
               txStQ <= ast_pkg::TX_IDLE;
               txLineQ <= 1'b1;
            end
            else if (prePendQ || (txOn && !txOnQ))
            begin
               prePendQ <= 1'b0;
               txStQ <= ast_pkg::TX_PRE;
               txShQ <= 10'h3FF;
               txLineQ <= 1'b1;
            end
            else if (ctrl2Q[ast_pkg::C2_BRK])
            begin
               txStQ <= ast_pkg::TX_SHIFT;
               txShQ <= 10'h000;
               txLineQ <= 1'b0;
               brkTailQ <= 1'b1;
            end
            else if (brkTailQ)
            begin
               txStQ <= ast_pkg::TX_MARK;
               txBitQ <= frameBits - 4'h1;
               txShQ <= 10'h3FF;
               txLineQ <= 1'b1;
               brkTailQ <= 1'b0;
            end
            else if (tdrFullQ || (dataWr && txStQ == ast_pkg::TX_IDLE))
            begin
               txStQ <= ast_pkg::TX_SHIFT;
               tdrFullQ <= 1'b0;
               txShQ <= tdrFullQ ?
                  (wordLen ? {tdrQ, 1'b0} : {1'b1, tdrQ[7:0], 1'b0}) :
                  (wordLen ? {ctrl1Q[ast_pkg::C1_TX9], wDataQ[7:0], 1'b0} :
                             {1'b1, wDataQ[7:0], 1'b0});
               txLineQ <= 1'b0;
            end
            else
            begin
               txStQ <= ast_pkg::TX_IDLE;
               txLineQ <= 1'b1;
            end
         end
      end
   end
   // Empty flag set on the transfer that empties the holding buffer; done flag at frame end
   assign tdreSet = txOn && (txStQ == ast_pkg::TX_IDLE || frameEnd)
      && !prePendQ && !(txOn && !txOnQ) && !ctrl2Q[ast_pkg::C2_BRK] && !brkTailQ &&
      (tdrFullQ || (dataWr && txStQ == ast_pkg::TX_IDLE));
   assign tcSet = frameEnd && txStQ != ast_pkg::TX_PRE;
   assign serial_out_pin = txLineQ;
   assign serial_out_en = txOn || txStQ != ast_pkg::TX_IDLE;
   ////////////////////////////////////////////////////////////////////////////
   // Receiver
   logic rxS1Q, rxS2Q, rxOnQ, rxBusyQ, noiseQ, vote, voteNz;
   logic [3:0] rxOvsQ, rxBitQ, idleCntQ, idleOvsQ;
   logic [9:0] rxShQ;
   logic [2:0] smpQ;
   logic [8:0] rdrQ;
   logic rxDone, rxFrameErr, rxNoise, idleDet, idleArmQ;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rxS1Q <= 1'b1;
         rxS2Q <= 1'b1;
      end
      else
      begin
         rxS1Q <= serial_in_pin;
         rxS2Q <= rxS1Q;
      end
   end
   assign vote = (smpQ[0] & smpQ[1]) | (smpQ[1] & smpQ[2]) | (smpQ[0] & smpQ[2]);
   assign voteNz = !(smpQ == 3'b000 || smpQ == 3'b111);
   assign rxDone = rxBusyQ && tick16[1] && rxOvsQ == ast_pkg::OVS_LAST &&
      rxBitQ == frameBits - 4'h1;
   assign rxFrameErr = !vote;
   assign rxNoise = noiseQ || voteNz;
   assign idleDet = idleArmQ && rxOn && !rxBusyQ && tick16[1] && idleOvsQ == ast_pkg::OVS_LAST
      && idleCntQ == frameBits - 4'h1;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rxBusyQ <= 1'b0;
         rxOvsQ <= 4'h0;
         rxBitQ <= 4'h0;
         rxShQ <= 10'h0;
         smpQ <= 3'h7;
         noiseQ <= 1'b0;
         rxOnQ <= 1'b0;
      end
      else
      begin
         rxOnQ <= rxOn;
         if (!rxOn || !rxOnQ)
            rxBusyQ <= 1'b0;
         else if (tick16[1])
         begin
            if (!rxBusyQ)
            begin
               if (!rxS2Q)
               begin
                  rxBusyQ <= 1'b1;
                  rxOvsQ <= 4'h1;
                  rxBitQ <= 4'h0;
                  noiseQ <= 1'b0;
               end
            end
            else
            begin
               rxOvsQ <= rxOvsQ + 4'h1;
               if (rxOvsQ == ast_pkg::OVS_S1)
                  smpQ[0] <= rxS2Q;
               if (rxOvsQ == ast_pkg::OVS_S2)
                  smpQ[1] <= rxS2Q;
               if (rxOvsQ == ast_pkg::OVS_S3)
                  smpQ[2] <= rxS2Q;
               if (rxOvsQ == ast_pkg::OVS_LAST)
               begin
                  rxBitQ <= rxBitQ + 4'h1;
                  rxShQ <= {vote, rxShQ[9:1]};
                  noiseQ <= rxNoise;
                  if (rxBitQ == 4'h0 && vote)
                     rxBusyQ <= 1'b0; // False start
                  if (rxDone)
                     rxBusyQ <= 1'b0;
               end
            end
         end
      end
   end
   // Idle detection counts a full character of high after activity
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !rxOn || rxBusyQ || !rxS2Q)
      begin
         idleCntQ <= 4'h0;
         idleOvsQ <= 4'h0;
      end
      else if (tick16[1])
      begin
         idleOvsQ <= idleOvsQ + 4'h1;
         if (idleOvsQ == ast_pkg::OVS_LAST)
            idleCntQ <= idleDet ? 4'h0 : idleCntQ + 4'h1;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n || idleDet)
         idleArmQ <= 1'b0;
      else if (rxBusyQ)
         idleArmQ <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Status flags: hardware set wins over software clear
   logic clrTx, clrRx;
   assign clrTx = dataWr && statSeenQ;
   assign clrRx = dataRd && statSeenQ;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         statSeenQ <= 1'b0;
      else if (rdFire && s_axi_araddr == ast_pkg::STAT_OFS)
         statSeenQ <= 1'b1;
      else if (dataWr || dataRd)
         statSeenQ <= 1'b0;
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         statQ <= ast_pkg::STAT_RST;
         rdrQ <= 9'h0;
      end
      else
      begin
         if (clrTx)
         begin
            statQ[ast_pkg::S_TX_EMPTY_FLAG] <= 1'b0;
            statQ[ast_pkg::S_TC] <= 1'b0;
         end
         if (clrRx)
         begin
            statQ[ast_pkg::S_RX_FULL_FLAG] <= 1'b0;
            statQ[ast_pkg::S_IDLE] <= 1'b0;
            statQ[ast_pkg::S_OR] <= 1'b0;
            statQ[ast_pkg::S_NF] <= 1'b0;
            statQ[ast_pkg::S_FE] <= 1'b0;
         end
         if (tdreSet)
            statQ[ast_pkg::S_TX_EMPTY_FLAG] <= 1'b1;
         if (tcSet)
            statQ[ast_pkg::S_TC] <= 1'b1;
         if (idleDet)
            statQ[ast_pkg::S_IDLE] <= 1'b1;
         if (rxDone)
         begin
            if (statQ[ast_pkg::S_RX_FULL_FLAG] && !clrRx)
               statQ[ast_pkg::S_OR] <= 1'b1;
            else
            begin
               statQ[ast_pkg::S_RX_FULL_FLAG] <= 1'b1;
               statQ[ast_pkg::S_NF] <= rxNoise;
               statQ[ast_pkg::S_FE] <= rxFrameErr;
               // Shift word aligned above the start bit
               rdrQ <= wordLen ? rxShQ[9:1] : {1'b0, rxShQ[9:2]};
            end
         end
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         ctrl1Q[ast_pkg::C1_RX9] <= 1'b0;
      else if (rxDone && !(statQ[ast_pkg::S_RX_FULL_FLAG] && !clrRx) && wordLen)
         ctrl1Q[ast_pkg::C1_RX9] <= rxShQ[9];
   end
   // One combined request line
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= (statQ[ast_pkg::S_TX_EMPTY_FLAG] && ctrl2Q[ast_pkg::C2_TEIE]) ||
            (statQ[ast_pkg::S_TC] && ctrl2Q[ast_pkg::C2_TX_DONE_IRQ_EN]) ||
            ((statQ[ast_pkg::S_RX_FULL_FLAG] || statQ[ast_pkg::S_OR]) && ctrl2Q[ast_pkg::C2_RIE]) ||
            (statQ[ast_pkg::S_IDLE] && ctrl2Q[ast_pkg::C2_IDLE_IRQ_EN]);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= ast_pkg::AXI_OKAY;
      end
      else if (rdFire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= ast_pkg::AXI_OKAY;
         unique case (s_axi_araddr)
            ast_pkg::CTRL1_OFS: s_axi_rdata <= {24'h0, ctrl1Q};
            ast_pkg::CTRL2_OFS: s_axi_rdata <= {24'h0, ctrl2Q};
            ast_pkg::STAT_OFS: s_axi_rdata <= {24'h0, statQ};
            ast_pkg::BAUD_OFS: s_axi_rdata <= {24'h0, baudQ};
            ast_pkg::DATA_OFS: s_axi_rdata <= {24'h0, rdrQ[7:0]};
            ast_pkg::RXEP_OFS: s_axi_rdata <= {24'h0, rxEpQ};
            ast_pkg::TXEP_OFS: s_axi_rdata <= {24'h0, txEpQ};
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= ast_pkg::AXI_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_start_low;
      @(posedge mclk) disable iff (!rst_n)
      (txStQ == ast_pkg::TX_IDLE && dataWr && txOn && !prePendQ && txOnQ &&
       !ctrl2Q[ast_pkg::C2_BRK] && !brkTailQ) |=> !serial_out_pin;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_idle_high;
      @(posedge mclk) disable iff (!rst_n)
      (txStQ == ast_pkg::TX_IDLE) |-> serial_out_pin;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle line not high");
   property p_tx_clear;
      @(posedge mclk) disable iff (!rst_n)
      (clrTx && !tdreSet && !tcSet) |=> !statQ[ast_pkg::S_TX_EMPTY_FLAG] && !statQ[ast_pkg::S_TC];
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("tx flags not cleared");
   property p_no_clear_without_stat;
      @(posedge mclk) disable iff (!rst_n)
      (statQ[ast_pkg::S_RX_FULL_FLAG] && !statSeenQ) |=> statQ[ast_pkg::S_RX_FULL_FLAG];
   endproperty
   a_no_clear_without_stat: assert property (p_no_clear_without_stat)
      else $error("full flag cleared out of order");
   property p_overrun_keeps;
      @(posedge mclk) disable iff (!rst_n)
      (rxDone && statQ[ast_pkg::S_RX_FULL_FLAG] && !clrRx) |=>
         statQ[ast_pkg::S_OR] && $stable(rdrQ);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun lost");
   property p_rx_full;
      @(posedge mclk) disable iff (!rst_n)
      (rxDone && !statQ[ast_pkg::S_RX_FULL_FLAG]) |=> statQ[ast_pkg::S_RX_FULL_FLAG];
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("full flag not set");
   property p_tc_set;
      @(posedge mclk) disable iff (!rst_n)
      tcSet |=> statQ[ast_pkg::S_TC];
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("done flag not set");
   property p_disabled_release;
      @(posedge mclk) disable iff (!rst_n)
      !serial_out_en |=> txStQ == ast_pkg::TX_IDLE && serial_out_pin;
   endproperty
   a_disabled_release: assert property (p_disabled_release)
      else $error("pin driven while disabled");
endmodule : async_serial_transceiver

//--- tb/ast_far_end.sv
// Far-end serial equipment model
`timescale 1ns/1ns
module ast_far_end #(parameter int BIT = 16) (
   input wire logic mclk,
   input wire logic lineIn,
   output logic lineOut
);
   int cyc = 0;
   initial lineOut = 1'b1; // Mark level while idle
   always @(posedge mclk) cyc <= cyc + 1;
   // Frame bits go out from bit 0: start, data lsb first, stop
   task automatic send(input logic [9:0] frame);
      for (int i = 0; i < 10; i++)
      begin
         lineOut <= frame[i];
         repeat (BIT) @(posedge mclk);
      end
      lineOut <= 1'b1;
   endtask : send
   // Mid-bit sampling; a late start shows up in the start time
   task automatic recv(output logic [7:0] d, output logic stopBit, output int t);
      @(negedge lineIn);
      t = cyc;
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge mclk);
         d[i] = lineIn;
      end
      repeat (BIT) @(posedge mclk);
      stopBit = lineIn;
   endtask : recv
endmodule : ast_far_end

//--- tb/async_serial_transceiver_tb.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/1ns
module async_serial_transceiver_tb;
   logic mclk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, serial_in_pin, serial_out_pin, serial_out_en, irq;
   logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, rr;
   logic [7:0] d;
   logic s;
   int num_errors = 0, checks_done = 0, cyc = 0, t0, t;
   async_serial_transceiver dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in_pin, .serial_out_pin,
      .serial_out_en, .irq);
   ast_far_end far (.mclk(mclk), .lineIn(serial_out_pin), .lineOut(serial_in_pin));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Entered just after a rising edge; ready judged at the settled falling edge
   task automatic wr(input logic [4:0] a, input logic [31:0] dt, output logic [1:0] rs);
      logic aw, w, a1, w1;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw && w))
      begin
         @(negedge mclk);
         a1 = s_axi_awvalid && s_axi_awready;
         w1 = s_axi_wvalid && s_axi_wready;
         @(posedge mclk);
         if (a1) s_axi_awvalid <= 0;
         if (w1) s_axi_wvalid <= 0;
         aw = aw | a1;
         w = w | w1;
      end
      do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] dt);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(negedge mclk); while (s_axi_arready !== 1'b1);
      @(posedge mclk);
      s_axi_arvalid <= 0;
      do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
      dt = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
   endtask : rd
   task automatic bit_of(input int b, input logic e, input string nm);
      rd(ast_pkg::STAT_OFS, v);
      chk(nm, e, v[b]);
   endtask : bit_of
   task automatic results;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_bad;
      rd(ast_pkg::STAT_OFS, v);
      chk("status reset", 32'h000000C0, v);
      chk("pin idle", 1, serial_out_pin);
      chk("out off", 0, serial_out_en);
      rd(5'h1C, v);
      chk("rd unmapped", ast_pkg::AXI_SLVERR, rr);
      wr(5'h1C, 32'h0, r);
      chk("unmapped", ast_pkg::AXI_SLVERR, r);
      wr(ast_pkg::STAT_OFS, 32'h0, r);
      chk("status ro", ast_pkg::AXI_SLVERR, r);
   endtask : t_reset_bad
   task automatic t_tx;
      wr(ast_pkg::BAUD_OFS, 32'h0, r);
      wr(ast_pkg::CTRL2_OFS, 32'h48, r);
      t0 = far.cyc;
      chk("out en", 1, serial_out_en);
      rd(ast_pkg::STAT_OFS, v);
      wr(ast_pkg::DATA_OFS, 32'hA5, r);
      // Second byte only once the first has left the holding buffer
      fork
         begin
            far.recv(d, s, t);
            chk("preamble", 1, (t - t0 >= 150) && (t - t0 <= 180));
            chk("tx byte", 8'hA5, d);
            chk("stop", 1, s);
            far.recv(d, s, t);
            chk("tx queued", 8'h3C, d);
         end
         begin
            do rd(ast_pkg::STAT_OFS, v); while (v[ast_pkg::S_TX_EMPTY_FLAG] !== 1'b1);
            wr(ast_pkg::DATA_OFS, 32'h3C, r);
         end
      join
      repeat (40) @(posedge mclk);
      bit_of(ast_pkg::S_TC, 1, "tx done");
      chk("done irq", 1, irq);
      wr(ast_pkg::DATA_OFS, 32'h00, r);
      bit_of(ast_pkg::S_TC, 0, "done clr");
      wr(ast_pkg::CTRL2_OFS, 32'h49, r);
      far.recv(d, s, t);
      chk("break stop", 0, s);
      wr(ast_pkg::CTRL2_OFS, 32'h48, r);
      repeat (40) @(posedge mclk);
      chk("break tail", 1, serial_out_pin);
   endtask : t_tx
   task automatic t_rx;
      wr(ast_pkg::CTRL2_OFS, 32'h2C, r);
      far.send({1'b1, 8'h96, 1'b0});
      repeat (20) @(posedge mclk);
      chk("rx irq", 1, irq);
      bit_of(ast_pkg::S_RX_FULL_FLAG, 1, "rx full");
      rd(ast_pkg::DATA_OFS, v);
      chk("rx byte", 8'h96, v);
      bit_of(ast_pkg::S_RX_FULL_FLAG, 0, "full clr");
      far.send({1'b1, 8'h11, 1'b0});
      far.send({1'b1, 8'h22, 1'b0});
      repeat (20) @(posedge mclk);
      bit_of(ast_pkg::S_OR, 1, "overrun");
      rd(ast_pkg::DATA_OFS, v);
      chk("kept", 8'h11, v);
      bit_of(ast_pkg::S_OR, 0, "or clr");
      far.send(10'h000);
      repeat (40) @(posedge mclk);
      bit_of(ast_pkg::S_FE, 1, "framing");
      rd(ast_pkg::DATA_OFS, v);
      chk("break data", 8'h00, v);
      bit_of(ast_pkg::S_FE, 0, "fe clr");
      repeat (200) @(posedge mclk);
      bit_of(ast_pkg::S_IDLE, 1, "idle");
   endtask : t_rx
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_n <= 1;
      @(posedge mclk);
      t_reset_bad();
      t_tx();
      t_rx();
      results();
   end
endmodule : async_serial_transceiver_tb
